//--- cbbr_cfg_regs.v
// Functional notes
// - interrupt line at 3Ch: 8-bit read/write, resets to FFh
// - interrupt pin at 3Dh: read-only, default 01h, depends on signalling mode
// - bridge control at 3Eh resets 0340h; bits 15-11 read zero
// - bit 10 enables burst write posting both ways through the socket
// - bits 9 and 8 mark windows 1 and 0 prefetchable; both default 1
// - bit 7 routes card interrupts: 0 to PCI lines, 1 to legacy IRQ
// - bit 6 asserts card reset (default set); host reset also asserts it
// - bit 5: master aborts unreported, or target abort plus SERR if enabled
// - bit 4 reserved, read-only, reads zero
// - bit 3 set forwards accesses to VGA addresses
// - bit 2 set withholds upper 768 bytes of each 1K ISA I/O block
// - bit 1 forwards card system error to host SERR when set, if SERR enabled
// - bit 0: card parity errors ignored, or reported on CPERR when set
// - subsystem_maker_ident at 40h writable only with subsystem write enable
// - subsystem_board_ident at 42h writable only with subsystem write enable
// - legacy base at 44h decodes index port, next byte is data port
// - legacy base word aligned anywhere in 32-bit I/O; bit 0 reads 1
`timescale 1ns/100ps
`default_nettype none
`include "cbbr_regs.vh"

module cbbr_cfg_regs #(
  parameter [7:0] FUNC_PIN_VALUE = `CBBR_RST_INTPIN
) (
  input  wire        core_clk,
  input  wire        rst_n,
  // configuration cycle port
  input  wire        cfg_rd,
  input  wire        cfg_wr,
  input  wire [7:0]  cfg_addr,
  input  wire [3:0]  cfg_be,
  input  wire [31:0] cfg_wdata,
  output reg  [31:0] cfg_rdata_r,
  output reg         cfg_ack_r,
  // fields held by neighbouring registers
  input  wire        subsystem_write_enable,
  input  wire [1:0]  irq_signal_mode_sel,
  input  wire        pci_serr_enable,
  // host reset pin, active low
  input  wire        host_reset_input_n,
  // host cycles to classify
  input  wire        io_req,
  input  wire        mem_req,
  input  wire [31:0] req_addr,
  // card-side events
  input  wire        card_master_abort,
  input  wire        card_syserr,
  input  wire        card_parity_err,
  // control levels to the bridge core
  output wire        write_post_enable,
  output wire        window0_prefetchable,
  output wire        window1_prefetchable,
  output wire        func_irq_route_sel,
  output wire        master_abort_report_sel,
  output wire [7:0]  irq_line_route,
  output reg         card_reset_n_r,
  // decode results
  output wire        legacy_index_hit,
  output wire        legacy_data_hit,
  output wire        vga_forward_hit,
  output wire        isa_io_withhold,
  // error reports
  output wire        pci_target_abort,
  output wire        pci_serr_req,
  output wire        card_parity_report
);

  // stored state
  reg  [7:0]  intline_r;
  reg  [15:0] brctl_r;
  reg  [15:0] subven_r;
  reg  [15:0] subid_r;
  reg  [31:0] legbase_r;

  // per-lane byte enable expanded to a bit mask
  wire [31:0] lane_mask;

  // address decode of the dword being accessed
  wire [7:0]  dw_addr;
  wire        sel_3c;
  wire        sel_40;
  wire        sel_44;

  // read-side views
  wire [7:0]  intpin;
  wire [31:0] rd_3c;
  wire [31:0] rd_40;
  wire [31:0] rd_44;
  reg  [31:0] rdata_nxt;

  // write-side next values
  wire [31:0] wr_3c;
  wire [31:0] wr_40;
  wire [31:0] wr_44;
  wire [31:0] mask_3c;
  wire [31:0] mask_40;

  genvar i;

  // one byte enable covers eight data bits
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_lane
      assign lane_mask[8*i+7:8*i] = {8{cfg_be[i]}};
    end
  endgenerate

  assign dw_addr = {cfg_addr[7:2], 2'b00};
  assign sel_3c  = (dw_addr == `CBBR_OFF_INTLINE);
  assign sel_40  = (dw_addr == `CBBR_OFF_SUBVEN);
  assign sel_44  = (dw_addr == `CBBR_OFF_LEGBASE);

  // pin report follows the signalling mode; one code reports no pin
  assign intpin = (irq_signal_mode_sel == `CBBR_MODE_NOPIN) ? 8'h00 : FUNC_PIN_VALUE;

  // reserved bridge control bits are never stored, so they read zero
  assign rd_3c = {brctl_r & `CBBR_BRCTL_WMASK, intpin, intline_r};
  assign rd_40 = {subid_r, subven_r};
  assign rd_44 = {legbase_r[31:1], 1'b1};

  // writable mask per dword: the pin byte is read-only
  assign mask_3c = lane_mask & {`CBBR_BRCTL_WMASK, 8'h00, 8'hff};
  // subsystem ids only accept data while the enable is set
  assign mask_40 = subsystem_write_enable ? lane_mask : 32'h0000_0000;

  // merge new data into the stored value under the writable mask
  assign wr_3c = ({brctl_r, 8'h00, intline_r} & ~mask_3c) | (cfg_wdata & mask_3c);
  assign wr_40 = ({subid_r, subven_r} & ~mask_40) | (cfg_wdata & mask_40);
  assign wr_44 = (legbase_r & ~(lane_mask & `CBBR_LEG_WMASK)) |
                 (cfg_wdata & lane_mask & `CBBR_LEG_WMASK);

  // read multiplexer; unmapped dwords read as zero
  always @* begin
    rdata_nxt = 32'h0000_0000;
    if (sel_3c) begin
      rdata_nxt = rd_3c;
    end else if (sel_40) begin
      rdata_nxt = rd_40;
    end else if (sel_44) begin
      rdata_nxt = rd_44;
    end
  end

  // interrupt line and bridge control share the 3Ch dword
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      intline_r <= `CBBR_RST_INTLINE;
      brctl_r   <= `CBBR_RST_BRCTL;
    end else if (cfg_wr && sel_3c) begin
      intline_r <= wr_3c[7:0];
      brctl_r   <= wr_3c[31:16];
    end
  end

  // subsystem identification, writable only while enabled
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      subven_r <= `CBBR_RST_SUBVEN;
      subid_r  <= `CBBR_RST_SUBID;
    end else if (cfg_wr && sel_40) begin
      subven_r <= wr_40[15:0];
      subid_r  <= wr_40[31:16];
    end
  end

  // legacy index/data port base; bit 0 stays at its reset value
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      legbase_r <= `CBBR_RST_LEGBASE;
    end else if (cfg_wr && sel_44) begin
      legbase_r <= wr_44;
    end
  end

  // answer every configuration cycle one clock later, mapped or not
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ack_r   <= 1'b0;
      cfg_rdata_r <= 32'h0000_0000;
    end else begin
      cfg_ack_r <= cfg_rd | cfg_wr;
      if (cfg_rd) begin
        cfg_rdata_r <= rdata_nxt;
      end
    end
  end

  // card reset pin: asserted under reset, by the control bit, or by host reset
  // registered so a glitch on the host pin between clock edges cannot reach the card
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      card_reset_n_r <= 1'b0;
    end else begin
      card_reset_n_r <= ~(brctl_r[`CBBR_BC_CARD_RST] | ~host_reset_input_n);
    end
  end

  // control levels straight from the stored bits
  assign write_post_enable       = brctl_r[`CBBR_BC_POST];
  assign window1_prefetchable    = brctl_r[`CBBR_BC_PF1];
  assign window0_prefetchable    = brctl_r[`CBBR_BC_PF0];
  assign func_irq_route_sel      = brctl_r[`CBBR_BC_IRQ_ROUTE];
  assign master_abort_report_sel = brctl_r[`CBBR_BC_MABT];
  assign irq_line_route          = intline_r;

  // address classification for forwarding decisions
  cbbr_addr_decode u_decode (
    .core_clk             (core_clk),
    .rst_n                (rst_n),
    .io_req               (io_req),
    .mem_req              (mem_req),
    .req_addr             (req_addr),
    .legacy_base          (legbase_r),
    .vga_forward_enable   (brctl_r[`CBBR_BC_VGA]),
    .isa_io_filter_enable (brctl_r[`CBBR_BC_ISA]),
    .legacy_index_hit_r   (legacy_index_hit),
    .legacy_data_hit_r    (legacy_data_hit),
    .vga_forward_hit_r    (vga_forward_hit),
    .isa_io_withhold_r    (isa_io_withhold)
  );

  // error and abort reporting toward the host
  cbbr_err_route u_err (
    .core_clk                    (core_clk),
    .rst_n                       (rst_n),
    .card_master_abort           (card_master_abort),
    .card_syserr                 (card_syserr),
    .card_parity_err             (card_parity_err),
    .pci_serr_enable             (pci_serr_enable),
    .master_abort_report_sel     (brctl_r[`CBBR_BC_MABT]),
    .card_syserr_forward_enable  (brctl_r[`CBBR_BC_CSERR]),
    .card_parity_response_enable (brctl_r[`CBBR_BC_CPERR]),
    .pci_target_abort_r          (pci_target_abort),
    .pci_serr_req_r              (pci_serr_req),
    .card_parity_report_r        (card_parity_report)
  );

endmodule
`default_nettype wire

//--- cbbr_regs.vh
`ifndef CBBR_REGS_VH
`define CBBR_REGS_VH

// configuration byte offsets (dword aligned words hold several registers)
`define CBBR_OFF_INTLINE   8'h3c
`define CBBR_OFF_INTPIN    8'h3d
`define CBBR_OFF_BRCTL     8'h3e
`define CBBR_OFF_SUBVEN    8'h40
`define CBBR_OFF_SUBID     8'h42
`define CBBR_OFF_LEGBASE   8'h44

// reset values
`define CBBR_RST_INTLINE   8'hff
`define CBBR_RST_INTPIN    8'h01
`define CBBR_RST_BRCTL     16'h0340
`define CBBR_RST_SUBVEN    16'h0000
`define CBBR_RST_SUBID     16'h0000
`define CBBR_RST_LEGBASE   32'h0000_0001

// bridge control field positions
`define CBBR_BC_CPERR      0
`define CBBR_BC_CSERR      1
`define CBBR_BC_ISA        2
`define CBBR_BC_VGA        3
`define CBBR_BC_MABT       5
`define CBBR_BC_CARD_RST   6
`define CBBR_BC_IRQ_ROUTE  7
`define CBBR_BC_PF0        8
`define CBBR_BC_PF1        9
`define CBBR_BC_POST       10

// writable bits: 15..11 and 4 are reserved
`define CBBR_BRCTL_WMASK   16'h07ef
// legacy base: bit 0 is read-only
`define CBBR_LEG_WMASK     32'hffff_fffe

// interrupt signalling mode code with no pin reported
`define CBBR_MODE_NOPIN    2'b11

// isa range: 64 KB, last 768 bytes of every 1 KB block withheld
`define CBBR_ISA_TOP_HI    16'h0000

// vga ranges
`define CBBR_VGA_MEM_LO    32'h000a_0000
`define CBBR_VGA_MEM_HI    32'h000b_ffff
`define CBBR_VGA_IO_A_LO   10'h3b0
`define CBBR_VGA_IO_A_HI   10'h3bb
`define CBBR_VGA_IO_B_LO   10'h3c0
`define CBBR_VGA_IO_B_HI   10'h3df

`endif

//--- cbbr_addr_decode.v
`timescale 1ns/100ps
`default_nettype none
`include "cbbr_regs.vh"

// classifies host i/o and memory cycles against the vga, isa and legacy ports
module cbbr_addr_decode (
  input  wire        core_clk,
  input  wire        rst_n,
  input  wire        io_req,
  input  wire        mem_req,
  input  wire [31:0] req_addr,
  input  wire [31:0] legacy_base,
  input  wire        vga_forward_enable,
  input  wire        isa_io_filter_enable,
  output reg         legacy_index_hit_r,
  output reg         legacy_data_hit_r,
  output reg         vga_forward_hit_r,
  output reg         isa_io_withhold_r
);

  wire [31:0] idx_addr;
  wire        vga_mem;
  wire        vga_io;
  wire        isa_top;

  // index port on the even byte, data port on the next byte
  assign idx_addr = {legacy_base[31:1], 1'b0};
  assign vga_mem  = (req_addr >= `CBBR_VGA_MEM_LO) && (req_addr <= `CBBR_VGA_MEM_HI);
  assign vga_io   = (req_addr[31:10] == 22'h00_0000) &&
                    (((req_addr[9:0] >= `CBBR_VGA_IO_A_LO) && (req_addr[9:0] <= `CBBR_VGA_IO_A_HI)) ||
                     ((req_addr[9:0] >= `CBBR_VGA_IO_B_LO) && (req_addr[9:0] <= `CBBR_VGA_IO_B_HI)));
  // upper 768 bytes of a 1 KB block have address bits 9..8 non-zero
  assign isa_top  = (req_addr[31:16] == `CBBR_ISA_TOP_HI) && (req_addr[9:8] != 2'b00);

  // registered so the outputs stay glitch free for the forwarding logic
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      legacy_index_hit_r <= 1'b0;
      legacy_data_hit_r  <= 1'b0;
      vga_forward_hit_r  <= 1'b0;
      isa_io_withhold_r  <= 1'b0;
    end else begin
      legacy_index_hit_r <= io_req && (req_addr == idx_addr);
      legacy_data_hit_r  <= io_req && (req_addr == (idx_addr + 32'h0000_0001));
      vga_forward_hit_r  <= vga_forward_enable &&
                            ((mem_req && vga_mem) || (io_req && vga_io));
      isa_io_withhold_r  <= isa_io_filter_enable && io_req && isa_top;
    end
  end

endmodule
`default_nettype wire

//--- cbbr_err_route.v
`timescale 1ns/100ps
`default_nettype none

// turns card-side error events into host-side reports per the control bits
module cbbr_err_route (
  input  wire core_clk,
  input  wire rst_n,
  input  wire card_master_abort,
  input  wire card_syserr,
  input  wire card_parity_err,
  input  wire pci_serr_enable,
  input  wire master_abort_report_sel,
  input  wire card_syserr_forward_enable,
  input  wire card_parity_response_enable,
  output reg  pci_target_abort_r,
  output reg  pci_serr_req_r,
  output reg  card_parity_report_r
);

  wire abort_rep;

  // a card master abort is silent unless reporting is selected
  assign abort_rep = card_master_abort && master_abort_report_sel;

  // report flags follow the events, one clock behind them
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pci_target_abort_r   <= 1'b0;
      pci_serr_req_r       <= 1'b0;
      card_parity_report_r <= 1'b0;
    end else begin
      pci_target_abort_r   <= abort_rep;
      pci_serr_req_r       <= pci_serr_enable &&
                              (abort_rep || (card_syserr && card_syserr_forward_enable));
      card_parity_report_r <= card_parity_err && card_parity_response_enable;
    end
  end

endmodule
`default_nettype wire

//--- cbbr_cfg_regs_asserts.sv
`timescale 1ns/100ps
`default_nettype none
// port-level checks of the bridge register bank
module cbbr_cfg_regs_asserts #(
  parameter [7:0] FUNC_PIN_VALUE = 8'h01
) (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        cfg_rd,
  input wire logic [7:0]  cfg_addr,
  input wire logic [31:0] cfg_rdata_r,
  input wire logic [1:0]  irq_signal_mode_sel,
  input wire logic        pci_serr_enable,
  input wire logic        host_reset_input_n,
  input wire logic        io_req,
  input wire logic        card_master_abort,
  input wire logic        master_abort_report_sel,
  input wire logic        card_reset_n_r,
  input wire logic        legacy_index_hit,
  input wire logic        legacy_data_hit,
  input wire logic        isa_io_withhold,
  input wire logic        pci_target_abort,
  input wire logic        pci_serr_req
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // reads of the control word and of the legacy base word
  sequence ctl_rd_s; cfg_rd && cfg_addr[7:2] == 6'h0f; endsequence
  sequence leg_rd_s; cfg_rd && cfg_addr[7:2] == 6'h11; endsequence
  resv_zero_a: assert property (ctl_rd_s |=> cfg_rdata_r[31:27] == 5'h0 && !cfg_rdata_r[20])
    else $error("reserved control bits set");
  pin_mode_a: assert property (ctl_rd_s |=>
    cfg_rdata_r[15:8] == ($past(irq_signal_mode_sel) == 2'b11 ? 8'h00 : FUNC_PIN_VALUE))
    else $error("pin value wrong");
  leg_bit0_a: assert property (leg_rd_s |=> cfg_rdata_r[0])
    else $error("legacy base bit 0 low");
  rdata_hold_a: assert property (!cfg_rd |=> $stable(cfg_rdata_r))
    else $error("read data moved");
  // host reset must reach the card within one cycle
  card_rst_host_a: assert property (!host_reset_input_n |=> !card_reset_n_r)
    else $error("card reset missed");
  abort_route_a: assert property (1'b1 |=>
    pci_target_abort == $past(card_master_abort && master_abort_report_sel))
    else $error("target abort wrong");
  serr_gate_a: assert property (!pci_serr_enable |=> !pci_serr_req)
    else $error("serr while disabled");
  io_idle_a: assert property (!io_req |=> !(legacy_index_hit || legacy_data_hit || isa_io_withhold))
    else $error("io decode without cycle");
endmodule
bind cbbr_cfg_regs cbbr_cfg_regs_asserts #(.FUNC_PIN_VALUE(FUNC_PIN_VALUE)) u_chk (
  .core_clk, .rst_n, .cfg_rd, .cfg_addr, .cfg_rdata_r, .irq_signal_mode_sel, .pci_serr_enable,
  .host_reset_input_n, .io_req, .card_master_abort, .master_abort_report_sel, .card_reset_n_r,
  .legacy_index_hit, .legacy_data_hit, .isa_io_withhold, .pci_target_abort, .pci_serr_req);
`default_nettype wire

//--- cbbr_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// host issuing one-cycle configuration requests
module cbbr_host_model (
  input  wire logic        core_clk,
  input  wire logic        cfg_ack_r,
  input  wire logic [31:0] cfg_rdata_r,
  output var logic         cfg_rd,
  output var logic         cfg_wr,
  output var logic [7:0]   cfg_addr,
  output var logic [3:0]   cfg_be,
  output var logic [31:0]  cfg_wdata
);
  int lost = 0;
  initial {cfg_rd, cfg_wr, cfg_addr, cfg_be, cfg_wdata} = '0;
  // request stands one cycle, then the acknowledge is awaited a bounded time
  task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] b,
                      input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge core_clk);
    {cfg_rd, cfg_wr, cfg_addr, cfg_be, cfg_wdata} <= {!w, w, a, b, d};
    @(posedge core_clk);
    {cfg_rd, cfg_wr} <= 2'b00;
    cfg_wdata <= ~d; // stale data must not look valid
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (cfg_ack_r !== 1'b1 && n < 4);
    if (cfg_ack_r !== 1'b1) lost++;
    q = cfg_rdata_r;
  endtask
endmodule
`default_nettype wire

//--- cbbr_cfg_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none
module cbbr_cfg_regs_tb;
  logic        core_clk = 0, rst_n = 0, subsystem_write_enable = 0, pci_serr_enable = 0;
  logic        host_reset_input_n = 1, io_req = 0, mem_req = 0;
  logic [1:0]  irq_signal_mode_sel = 0;
  logic [2:0]  ev = 0;
  logic [31:0] req_addr = 0, q, cfg_wdata, cfg_rdata_r;
  logic        cfg_rd, cfg_wr, cfg_ack_r, write_post_enable, window0_prefetchable, window1_prefetchable;
  logic        func_irq_route_sel, master_abort_report_sel, card_reset_n_r, legacy_index_hit;
  logic        legacy_data_hit, vga_forward_hit, isa_io_withhold, pci_target_abort, pci_serr_req;
  logic        card_parity_report;
  logic [7:0]  cfg_addr, irq_line_route;
  logic [3:0]  cfg_be;
  int          miscompares = 0, tests_run = 0, cyc = 0;

  always #2 core_clk = ~core_clk;

  cbbr_host_model host (.core_clk, .cfg_ack_r, .cfg_rdata_r, .cfg_rd, .cfg_wr, .cfg_addr, .cfg_be, .cfg_wdata);
  cbbr_cfg_regs dut (.core_clk, .rst_n, .cfg_rd, .cfg_wr, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata_r,
    .cfg_ack_r, .subsystem_write_enable, .irq_signal_mode_sel, .pci_serr_enable, .host_reset_input_n,
    .io_req, .mem_req, .req_addr, .card_master_abort(ev[2]), .card_syserr(ev[1]), .card_parity_err(ev[0]),
    .write_post_enable, .window0_prefetchable, .window1_prefetchable, .func_irq_route_sel,
    .master_abort_report_sel, .irq_line_route, .card_reset_n_r, .legacy_index_hit, .legacy_data_hit,
    .vga_forward_hit, .isa_io_withhold, .pci_target_abort, .pci_serr_req, .card_parity_report);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    host.xfer(1'b1, a, b, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    host.xfer(1'b0, a, 4'hf, 32'h0000_0000, q);
    chk(q, e);
  endtask
  // one cycle of host traffic and card events; returns once outputs settle
  task automatic pulse(input logic [1:0] k, input logic [31:0] a, input logic [2:0] e);
    @(posedge core_clk);
    {io_req, mem_req, req_addr, ev} <= {k, a, e};
    @(posedge core_clk);
    {io_req, mem_req, ev} <= '0;
    #1;
  endtask
  function automatic logic [5:0] lv();
    return {write_post_enable, window1_prefetchable, window0_prefetchable,
            func_irq_route_sel, master_abort_report_sel, card_reset_n_r};
  endfunction

  task automatic t_reset;
    rd(8'h3c, 32'h0340_01ff);
    rd(8'h40, 32'h0000_0000);
    rd(8'h44, 32'h0000_0001);
    rd(8'h48, 32'h0000_0000);
    chk({lv(), irq_line_route}, {6'b011000, 8'hff});
  endtask
  // all ones then zeros into the control word; reserved bits must not stick
  task automatic t_ctl;
    wr(8'h3c, 4'hf, 32'hffff_ff5a);
    rd(8'h3c, 32'h07ef_015a);
    chk(lv(), 6'b111110);
    wr(8'h3c, 4'hc, 32'h0000_0000);
    rd(8'h3c, 32'h0000_015a);
    chk(lv(), 6'b000001);
  endtask
  task automatic t_pin;
    for (int m = 0; m < 4; m++) begin
      irq_signal_mode_sel <= m[1:0];
      rd(8'h3c, {16'h0000, (m == 3) ? 8'h00 : 8'h01, 8'h5a});
    end
  endtask
  // host reset forces the card into reset without touching the registers
  task automatic t_hreset;
    @(posedge core_clk);
    host_reset_input_n <= 0;
    @(posedge core_clk);
    #1;
    chk(card_reset_n_r, 0);
    @(posedge core_clk);
    host_reset_input_n <= 1;
    @(posedge core_clk);
    #1;
    chk(card_reset_n_r, 1);
    // signalling mode is still the no-pin code left by the pin scenario
    rd(8'h3c, 32'h0000_005a);
  endtask
  task automatic t_subsys;
    wr(8'h40, 4'hf, 32'h1234_5678);
    rd(8'h40, 32'h0000_0000);
    subsystem_write_enable <= 1;
    wr(8'h40, 4'hf, 32'h1234_5678);
    rd(8'h40, 32'h1234_5678);
    wr(8'h40, 4'h3, 32'h0000_0000);
    subsystem_write_enable <= 0;
    wr(8'h40, 4'hf, 32'hffff_ffff);
    rd(8'h40, 32'h1234_0000);
  endtask
  task automatic t_legacy;
    wr(8'h44, 4'hf, 32'h0000_0300);
    rd(8'h44, 32'h0000_0301);
    pulse(2'b10, 32'h0000_0300, 3'b000);
    chk({legacy_index_hit, legacy_data_hit}, 2'b10);
    pulse(2'b10, 32'h0000_0301, 3'b000);
    chk({legacy_index_hit, legacy_data_hit}, 2'b01);
    pulse(2'b01, 32'h0000_0300, 3'b000);
    chk({legacy_index_hit, legacy_data_hit}, 2'b00);
  endtask
  // cycle kind, address, expected {vga, withheld}; last two with both enables off
  task automatic t_decode;
    logic [35:0] d [7] = '{{2'b10, 32'h0000_03c0, 2'b11}, {2'b01, 32'h000a_0000, 2'b10},
      {2'b10, 32'h0000_0100, 2'b01}, {2'b10, 32'h0000_0050, 2'b00}, {2'b10, 32'h0001_0100, 2'b00},
      {2'b10, 32'h0000_03c0, 2'b00}, {2'b10, 32'h0000_0100, 2'b00}};
    wr(8'h3c, 4'hc, 32'h000c_0000);
    for (int i = 0; i < 7; i++) begin
      if (i == 5) wr(8'h3c, 4'hc, 32'h0000_0000);
      pulse(d[i][35:34], d[i][33:2], 3'b000);
      chk({vga_forward_hit, isa_io_withhold}, d[i][1:0]);
    end
  endtask
  // abort, system error, parity in turn under three settings
  task automatic t_err;
    logic [2:0] x [9] = '{3'b110, 3'b010, 3'b001, 3'b000, 3'b000, 3'b000, 3'b100, 3'b000, 3'b001};
    for (int j = 0; j < 3; j++) begin
      pci_serr_enable <= (j != 2);
      wr(8'h3c, 4'hc, (j == 1) ? 32'h0000_0000 : 32'h0023_0000);
      for (int k = 0; k < 3; k++) begin
        pulse(2'b00, 32'h0000_0000, 3'b100 >> k);
        chk({pci_target_abort, pci_serr_req, card_parity_report}, x[j * 3 + k]);
      end
    end
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // hang guard, far above the roughly 130 cycles the run needs
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      final_report;
    end
  end

  initial begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1;
    t_reset;
    t_ctl;
    t_pin;
    t_hreset;
    t_subsys;
    t_legacy;
    t_decode;
    t_err;
    chk(host.lost, 0);
    final_report;
  end
endmodule
`default_nettype wire
